// ---- rtl/nch_defines.svh ----
`ifndef NCH_DEFINES_SVH
`define NCH_DEFINES_SVH

// ****************************************************************
// Command bytes
// ****************************************************************
`define NCH_CMD_COL_READ 8'h05
`define NCH_CMD_PLANE_READ 8'h06
`define NCH_CMD_CONFIRM 8'hE0
`define NCH_CMD_COL_INPUT 8'h85
`define NCH_CMD_STATUS_ENH 8'h78

// ****************************************************************
// Row address field positions
// ****************************************************************
`define NCH_PLANE_BIT 6
`define NCH_LUN_BIT 17

// ****************************************************************
// Timing
// ****************************************************************
`define NCH_CLK_MHZ 50
`define NCH_T_CMD_TO_OUTPUT_NS 60
`define NCH_T_ADDR_TO_DATA_NS 70
`define NCH_WHR_CYC ((`NCH_T_CMD_TO_OUTPUT_NS * `NCH_CLK_MHZ + 999) / 1000)
`define NCH_ADL_CYC ((`NCH_T_ADDR_TO_DATA_NS * `NCH_CLK_MHZ + 999) / 1000)
`define NCH_WR_LOW_CYC 1
`define NCH_RD_LOW_CYC 3
`define NCH_HIGH_CYC 1

`endif

// ---- rtl/nch_pkg.sv ----
package nch_pkg;

  // ****************************************************************
  // Host operations and bus cycle kinds
  // ****************************************************************
  typedef enum logic [2:0] {
    OP_COL_READ = 3'h0,
    OP_PLANE_READ = 3'h1,
    OP_COL_INPUT = 3'h2,
    OP_RETARGET = 3'h3,
    OP_STATUS_ENH = 3'h4,
    OP_DATA_RD = 3'h5,
    OP_DATA_WR = 3'h6
  } nch_op_t;

  typedef enum logic [1:0] {
    CYC_CMD = 2'h0,
    CYC_ADDR = 2'h1,
    CYC_DIN = 2'h2,
    CYC_DOUT = 2'h3
  } nch_cyc_t;

  typedef logic [11:0] nch_col_t;
  typedef logic [17:0] nch_row_t;

endpackage : nch_pkg

// ---- rtl/nch_cyc_if.sv ----
`timescale 1ns/1ps

// ****************************************************************
// One bus cycle request from sequencer to pin engine
// ****************************************************************
interface nch_cyc_if;
  import nch_pkg::*;
  logic start; // One-cycle request pulse
  nch_cyc_t kind; // Cycle kind
  logic [7:0] wbyte; // Byte to drive
  logic done; // One-cycle completion pulse
  logic [7:0] rbyte; // Byte read on data output cycle
  modport seq (output start, output kind, output wbyte, input done, input rbyte);
  modport eng (input start, input kind, input wbyte, output done, output rbyte);
endinterface : nch_cyc_if

// ---- rtl/nch_cyc_eng.sv ----
`timescale 1ns/1ps
`include "nch_defines.svh"

module nch_cyc_eng
  import nch_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  nch_cyc_if.eng cyc,
  input wire logic [7:0] io_in,
  output logic cle,
  output logic ale,
  output logic we_n,
  output logic re_n,
  output logic [7:0] io_out,
  output logic io_oe
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef enum logic [3:0] {
    E_IDLE = 4'b0001,
    E_SETUP = 4'b0010,
    E_LOW = 4'b0100,
    E_HIGH = 4'b1000
  } nch_eng_t;

  nch_eng_t state_ff; // Cycle phase
  logic [1:0] cnt_ff; // Phase length counter
  nch_cyc_t kind_ff; // Kind of the cycle in flight
  logic [7:0] io_sync1_ff; // First sync stage of data pins
  logic [7:0] io_sync2_ff; // Second sync stage of data pins
  logic done_ff; // Completion pulse
  logic [7:0] rbyte_ff; // Captured read byte

  assign cyc.done = done_ff;
  assign cyc.rbyte = rbyte_ff;

  // Phase sequencing: setup, strobe low, strobe high
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_ff <= E_IDLE;
      cnt_ff <= 2'h0;
      kind_ff <= CYC_CMD;
    end else begin
      unique case (state_ff)
        E_IDLE: begin
          if (cyc.start) begin
            state_ff <= E_SETUP;
            kind_ff <= cyc.kind;
          end
        end
        E_SETUP: begin
          state_ff <= E_LOW;
          cnt_ff <= (kind_ff == CYC_DOUT) ? 2'(`NCH_RD_LOW_CYC - 1) : 2'(`NCH_WR_LOW_CYC - 1);
        end
        E_LOW: begin
          if (cnt_ff == 2'h0) begin
            state_ff <= E_HIGH;
            cnt_ff <= 2'(`NCH_HIGH_CYC - 1);
          end else begin
            cnt_ff <= cnt_ff - 2'h1;
          end
        end
        E_HIGH: begin
          if (cnt_ff == 2'h0) begin
            state_ff <= E_IDLE;
          end else begin
            cnt_ff <= cnt_ff - 2'h1;
          end
        end
      endcase
    end
  end

  // Pin drive: latches held through the whole cycle, strobe in LOW
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cle <= 1'b0;
      ale <= 1'b0;
      we_n <= 1'b1;
      re_n <= 1'b1;
      io_out <= 8'h00;
      io_oe <= 1'b0;
    end else if (state_ff == E_IDLE && cyc.start) begin
      cle <= (cyc.kind == CYC_CMD);
      ale <= (cyc.kind == CYC_ADDR);
      io_out <= cyc.wbyte;
      io_oe <= (cyc.kind != CYC_DOUT);
    end else if (state_ff == E_SETUP) begin
      // Strobe falls one cycle after latches settle
      if (kind_ff == CYC_DOUT) begin
        re_n <= 1'b0;
      end else begin
        we_n <= 1'b0;
      end
    end else if (state_ff == E_LOW && cnt_ff == 2'h0) begin
      we_n <= 1'b1;
      re_n <= 1'b1;
    end else if (state_ff == E_HIGH && cnt_ff == 2'h0) begin
      cle <= 1'b0;
      ale <= 1'b0;
      io_oe <= 1'b0;
    end
  end

  // Data pins come from outside, two stages before use
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      io_sync1_ff <= 8'h00;
      io_sync2_ff <= 8'h00;
    end else begin
      io_sync1_ff <= io_in;
      io_sync2_ff <= io_sync1_ff;
    end
  end

  // Read capture at the end of RE low, completion pulse at the end of the strobe high phase
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      done_ff <= 1'b0;
      rbyte_ff <= 8'h00;
    end else begin
      done_ff <= (state_ff == E_HIGH && cnt_ff == 2'h0);
      if (state_ff == E_LOW && cnt_ff == 2'h0 && kind_ff == CYC_DOUT) begin
        rbyte_ff <= io_sync2_ff;
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_latch_excl: assert property (!(cle && ale))
    else $error("command and address latch both high");
  a_read_no_drive: assert property (!re_n |-> !io_oe)
    else $error("data pins driven during read strobe");
  a_read_low_width: assert property ($fell(re_n) |-> !re_n [*3] ##1 re_n)
    else $error("read strobe low time wrong");

endmodule : nch_cyc_eng

// ---- rtl/nch_host.sv ----
`timescale 1ns/1ps
// Operation
// - 05h, two column cycles, then E0h
// - Wait command-to-output delay after E0h
// - Enhanced status before 05h on multi-die
// - 06h, two column, three row, E0h
// - 06h-E0h selects plane, may repeat
// - Enhanced status before 06h while busy (code refuses 06h unless ready and array_idle_flag set)
// - 85h, two column, then address-to-data delay
// - 85h only inside open program sequence
// - Retarget: 85h, five cycles, then delay
// - Retarget keeps die and plane bits
// - Retarget may mix with column reads
// - 85h overwrites bytes in internal move
`include "nch_defines.svh"

module nch_host
  import nch_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic req_valid,
  output logic req_ready,
  input wire nch_op_t req_op,
  input wire nch_col_t req_col,
  input wire nch_row_t req_row,
  input wire logic [7:0] req_wdata,
  output logic rsp_valid,
  output logic rsp_err,
  output logic [7:0] rsp_rdata,
  input wire logic array_idle_flag,
  input wire logic prog_open,
  input wire nch_row_t prog_row,
  input wire logic multi_die,
  input wire logic multi_die_start,
  output nch_col_t col_ptr,
  output logic ce_n,
  output logic cle,
  output logic ale,
  output logic we_n,
  output logic re_n,
  output logic [7:0] io_out,
  output logic io_oe,
  input wire logic [7:0] io_in,
  input wire logic rb_n
);

  // ****************************************************************
  // Functions
  // ****************************************************************
  // Opening command byte of each operation
  function automatic logic [7:0] cmd_byte(input nch_op_t op);
    case (op)
      OP_COL_READ: return `NCH_CMD_COL_READ;
      OP_PLANE_READ: return `NCH_CMD_PLANE_READ;
      OP_STATUS_ENH: return `NCH_CMD_STATUS_ENH;
      default: return `NCH_CMD_COL_INPUT;
    endcase
  endfunction : cmd_byte

  // Number of bus cycles of each operation
  function automatic logic [2:0] seq_len(input nch_op_t op);
    case (op)
      OP_COL_READ: return 3'h4;
      OP_PLANE_READ: return 3'h7;
      OP_COL_INPUT: return 3'h3;
      OP_RETARGET: return 3'h6;
      OP_STATUS_ENH: return 3'h4;
      default: return 3'h1;
    endcase
  endfunction : seq_len

  // Address byte by index: two column bytes then three row bytes
  function automatic logic [7:0] addr_byte(input nch_col_t col, input nch_row_t row,
                                           input logic [2:0] idx);
    case (idx)
      3'h0: return col[7:0];
      3'h1: return {4'h0, col[11:8]};
      3'h2: return row[7:0];
      3'h3: return row[15:8];
      default: return {6'h00, row[17:16]};
    endcase
  endfunction : addr_byte

  // Kind and byte of one step of an operation
  function automatic logic [9:0] seq_step(input nch_op_t op, input logic [2:0] step,
                                          input nch_col_t col, input nch_row_t row,
                                          input logic [7:0] wdata);
    logic [2:0] idx;
    idx = (op == OP_STATUS_ENH) ? 3'(step + 3'h1) : 3'(step - 3'h1);
    if (op == OP_DATA_RD) begin
      return {CYC_DOUT, 8'h00};
    end else if (op == OP_DATA_WR) begin
      return {CYC_DIN, wdata};
    end else if (step == 3'h0) begin
      return {CYC_CMD, cmd_byte(op)};
    end else if ((op == OP_COL_READ || op == OP_PLANE_READ) &&
                 step == 3'(seq_len(op) - 3'h1)) begin
      return {CYC_CMD, `NCH_CMD_CONFIRM};
    end else begin
      return {CYC_ADDR, addr_byte(col, row, idx)};
    end
  endfunction : seq_step

  // Wait after an operation before data may move
  function automatic logic [2:0] wait_for(input nch_op_t op);
    case (op)
      OP_COL_READ, OP_PLANE_READ, OP_STATUS_ENH: return 3'(`NCH_WHR_CYC);
      OP_COL_INPUT, OP_RETARGET: return 3'(`NCH_ADL_CYC);
      default: return 3'h0;
    endcase
  endfunction : wait_for

  // ****************************************************************
  // Declarations
  // ****************************************************************
  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_RUN = 3'b010,
    S_WAIT = 3'b100
  } nch_seq_t;

  nch_seq_t state_ff; // Sequencer state
  nch_seq_t nxt_state; // Next sequencer state
  logic rb_sync1_ff; // First sync stage of ready pin
  logic rb_sync2_ff; // Ready flag as seen by logic
  logic ready_ff; // Request port ready
  logic ce_n_ff; // Chip enable
  nch_op_t op_ff; // Operation in flight
  nch_col_t col_ff; // Its column
  nch_row_t row_ff; // Its row
  logic [7:0] wdata_ff; // Its write byte
  logic [2:0] step_ff; // Current step
  logic [2:0] wait_ff; // Remaining wait cycles
  logic start_ff; // Cycle start pulse
  nch_cyc_t kind_ff; // Cycle kind to engine
  logic [7:0] wbyte_ff; // Cycle byte to engine
  logic rsp_valid_ff; // Answer pulse
  logic rsp_err_ff; // Answer refused flag
  logic [7:0] rsp_rdata_ff; // Answer read byte
  logic out_mode_ff; // Die in data output mode
  logic in_mode_ff; // Die in data input mode
  logic stat_mode_ff; // Die in status output mode
  logic lun_sel_ff; // One die selected by enhanced status
  nch_col_t col_ptr_ff; // Host copy of column pointer
  logic refuse; // Request breaks an acceptance condition
  logic accept; // Request taken
  logic last_step; // Current step is the final one
  logic finish; // Operation completes this cycle
  logic advance; // Move to next step
  logic [9:0] nxt_cyc; // Next cycle kind and byte
  logic same_die_plane; // Retarget keeps die and plane

  nch_cyc_if u_cyc();

  nch_cyc_eng u_eng (
    .sys_clk(sys_clk),
    .rst(rst),
    .cyc(u_cyc.eng),
    .io_in(io_in),
    .cle(cle),
    .ale(ale),
    .we_n(we_n),
    .re_n(re_n),
    .io_out(io_out),
    .io_oe(io_oe)
  );

  assign u_cyc.start = start_ff;
  assign u_cyc.kind = kind_ff;
  assign u_cyc.wbyte = wbyte_ff;
  assign req_ready = ready_ff;
  assign rsp_valid = rsp_valid_ff;
  assign rsp_err = rsp_err_ff;
  assign rsp_rdata = rsp_rdata_ff;
  assign col_ptr = col_ptr_ff;
  assign ce_n = ce_n_ff;

  // ****************************************************************
  // Acceptance
  // ****************************************************************
  assign same_die_plane = (req_row[`NCH_LUN_BIT] == prog_row[`NCH_LUN_BIT]) &&
                          (req_row[`NCH_PLANE_BIT] == prog_row[`NCH_PLANE_BIT]);

  // Refuse operations the die would not take in its present state
  always_comb begin
    unique case (req_op)
      OP_COL_READ: refuse = !rb_sync2_ff || (multi_die && !lun_sel_ff);
      OP_PLANE_READ: refuse = !(rb_sync2_ff && array_idle_flag);
      OP_COL_INPUT: refuse = !rb_sync2_ff || !prog_open;
      OP_RETARGET: refuse = !rb_sync2_ff || !prog_open || !same_die_plane;
      OP_STATUS_ENH: refuse = 1'b0;
      OP_DATA_RD: refuse = !(out_mode_ff || stat_mode_ff);
      OP_DATA_WR: refuse = !in_mode_ff;
      default: refuse = 1'b1;
    endcase
  end

  assign accept = (state_ff == S_IDLE) && ready_ff && req_valid && !refuse;
  assign last_step = (step_ff == 3'(seq_len(op_ff) - 3'h1));
  assign finish = (state_ff == S_RUN) && u_cyc.done && last_step;
  assign advance = (state_ff == S_RUN) && u_cyc.done && !last_step;
  assign nxt_cyc = accept ? seq_step(req_op, 3'h0, req_col, req_row, req_wdata) :
                   seq_step(op_ff, 3'(step_ff + 3'h1), col_ff, row_ff, wdata_ff);

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  // Next state
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      S_IDLE: begin
        if (accept) begin
          nxt_state = S_RUN;
        end
      end
      S_RUN: begin
        if (finish) begin
          nxt_state = (wait_for(op_ff) != 3'h0) ? S_WAIT : S_IDLE;
        end
      end
      S_WAIT: begin
        if (wait_ff == 3'h1) begin
          nxt_state = S_IDLE;
        end
      end
    endcase
  end

  // State and ready register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_ff <= S_IDLE;
      ready_ff <= 1'b0;
      ce_n_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      ready_ff <= (nxt_state == S_IDLE);
      ce_n_ff <= 1'b0;
    end
  end

  // Ready pin sync
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rb_sync1_ff <= 1'b0;
      rb_sync2_ff <= 1'b0;
    end else begin
      rb_sync1_ff <= rb_n;
      rb_sync2_ff <= rb_sync1_ff;
    end
  end

  // Request capture and step counter
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      op_ff <= OP_COL_READ;
      col_ff <= 12'h000;
      row_ff <= 18'h00000;
      wdata_ff <= 8'h00;
      step_ff <= 3'h0;
    end else if (accept) begin
      op_ff <= req_op;
      col_ff <= req_col;
      row_ff <= req_row;
      wdata_ff <= req_wdata;
      step_ff <= 3'h0;
    end else if (advance) begin
      step_ff <= step_ff + 3'h1;
    end
  end

  // Bus cycle requests to the engine
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      start_ff <= 1'b0;
      kind_ff <= CYC_CMD;
      wbyte_ff <= 8'h00;
    end else begin
      start_ff <= accept || advance;
      if (accept || advance) begin
        kind_ff <= nch_cyc_t'(nxt_cyc[9:8]);
        wbyte_ff <= nxt_cyc[7:0];
      end
    end
  end

  // Host wait after the final cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wait_ff <= 3'h0;
    end else if (finish) begin
      wait_ff <= wait_for(op_ff);
    end else if (state_ff == S_WAIT) begin
      wait_ff <= wait_ff - 3'h1;
    end
  end

  // Answers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rsp_valid_ff <= 1'b0;
      rsp_err_ff <= 1'b0;
      rsp_rdata_ff <= 8'h00;
    end else begin
      rsp_valid_ff <= finish || (state_ff == S_IDLE && ready_ff && req_valid && refuse);
      rsp_err_ff <= (state_ff == S_IDLE && ready_ff && req_valid && refuse);
      if (finish && op_ff == OP_DATA_RD) begin
        rsp_rdata_ff <= u_cyc.rbyte;
      end
    end
  end

  // Die mode tracking; any command ends the previous mode
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      out_mode_ff <= 1'b0;
      in_mode_ff <= 1'b0;
      stat_mode_ff <= 1'b0;
    end else if (finish && op_ff != OP_DATA_RD && op_ff != OP_DATA_WR) begin
      out_mode_ff <= (op_ff == OP_COL_READ || op_ff == OP_PLANE_READ);
      in_mode_ff <= (op_ff == OP_COL_INPUT || op_ff == OP_RETARGET);
      stat_mode_ff <= (op_ff == OP_STATUS_ENH);
    end
  end

  // Die selection; a new selection wins over a multi-die start
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lun_sel_ff <= 1'b0;
    end else if (finish && op_ff == OP_STATUS_ENH) begin
      lun_sel_ff <= 1'b1;
    end else if (multi_die_start) begin
      lun_sel_ff <= 1'b0;
    end
  end

  // Column pointer copy
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      col_ptr_ff <= 12'h000;
    end else if (finish && (op_ff == OP_DATA_RD || op_ff == OP_DATA_WR)) begin
      col_ptr_ff <= col_ptr_ff + 12'h001;
    end else if (finish && op_ff != OP_STATUS_ENH) begin
      col_ptr_ff <= col_ff;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_col_read_ready: assert property (accept && req_op == OP_COL_READ |-> rb_sync2_ff)
    else $error("column read issued while busy");
  a_plane_read_idle: assert property (accept && req_op == OP_PLANE_READ |->
    rb_sync2_ff && array_idle_flag)
    else $error("plane read issued while not fully ready");
  a_input_in_program: assert property (accept && (req_op == OP_COL_INPUT ||
    req_op == OP_RETARGET) |-> prog_open && rb_sync2_ff)
    else $error("column input outside program sequence");
  a_retarget_same_die: assert property (accept && req_op == OP_RETARGET |->
    same_die_plane)
    else $error("retarget changed die or plane");
  a_status_first: assert property (accept && req_op == OP_COL_READ && multi_die |->
    lun_sel_ff)
    else $error("column read without die selection");
  a_output_wait: assert property (finish &&
    (op_ff == OP_COL_READ || op_ff == OP_PLANE_READ) |=> !req_ready [*3] ##1 req_ready)
    else $error("output wait wrong");
  a_input_wait: assert property (finish &&
    (op_ff == OP_COL_INPUT || op_ff == OP_RETARGET) |=> !req_ready [*4] ##1 req_ready)
    else $error("address to data wait wrong");
  a_confirm_last: assert property (start_ff && kind_ff == CYC_CMD &&
    wbyte_ff == `NCH_CMD_CONFIRM |-> last_step && step_ff != 3'h0)
    else $error("confirm byte out of place");
  a_col_advance: assert property (finish &&
    (op_ff == OP_DATA_RD || op_ff == OP_DATA_WR) |=> col_ptr == $past(col_ptr) + 12'h001)
    else $error("column pointer did not advance");
  a_mode_hold: assert property (out_mode_ff &&
    !(finish && op_ff != OP_DATA_RD && op_ff != OP_DATA_WR) |=> out_mode_ff)
    else $error("output mode dropped without command");

  c_col_read: cover property (finish && op_ff == OP_COL_READ);
  c_plane_read: cover property (finish && op_ff == OP_PLANE_READ);
  c_retarget: cover property (finish && op_ff == OP_RETARGET);
  c_data_read: cover property (finish && op_ff == OP_DATA_RD);

endmodule : nch_host

// ---- tb/nch_die_model.sv ----
`timescale 1ns/1ps
// ****************************************************************
// Behavioural die: cache register, column pointer, busy pin
// ****************************************************************
module nch_die_model (
  input wire logic sys_clk,
  input wire logic ce_n,
  input wire logic cle,
  input wire logic ale,
  input wire logic we_n,
  input wire logic re_n,
  input wire logic [7:0] io_out,
  input wire logic busy,
  output logic [7:0] io_in,
  output logic rb_n
);
  logic [7:0] mem [0:4095]; // Cache register
  logic [11:0] col; // Column pointer
  logic [17:0] row; // Destination row
  logic [7:0] cmd; // Last command byte
  logic [7:0] last = 8'hA5; // Last byte put out
  logic we_q; // Delayed write strobe
  logic re_q; // Delayed read strobe
  int na; // Address cycles since command
  assign rb_n = ~busy;
  // Released bus shows the inverse of the last byte
  assign io_in = (!ce_n && !re_n) ? mem[col] : ~last;
  // Latch each cycle on the strobe rising edge
  always @(posedge sys_clk) begin
    we_q <= we_n;
    re_q <= re_n;
    if (!ce_n && we_n && !we_q) begin
      if (cle) begin
        cmd <= io_out;
        // Enhanced status carries row bytes only
        na <= (io_out == 8'h78) ? 2 : 0;
      end else if (ale) begin
        if (na == 0) col[7:0] <= io_out;
        if (na == 1) col[11:8] <= io_out[3:0];
        if (na == 2) row[7:0] <= io_out;
        if (na == 3) row[15:8] <= io_out;
        if (na == 4) row[17:16] <= io_out[1:0];
        na <= na + 1;
      end else begin
        mem[col] <= io_out;
        col <= col + 12'h001;
      end
    end
    if (!ce_n && re_n && !re_q) begin
      last <= mem[col];
      col <= col + 12'h001;
    end
  end
endmodule : nch_die_model

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
// ****************************************************************
// Host bench: random column operations against the die model
// ****************************************************************
module tb_top;
  import nch_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  nch_op_t req_op = OP_COL_READ;
  nch_col_t req_col = 12'h000;
  nch_row_t req_row = 18'h00000;
  logic [7:0] req_wdata = 8'h00;
  logic array_idle_flag = 1'b1;
  logic prog_open = 1'b0;
  nch_row_t prog_row = 18'h20040; // Die and plane bits set
  logic multi_die = 1'b0;
  logic multi_die_start = 1'b0;
  logic busy = 1'b0; // Die busy request
  logic req_ready, rsp_valid, rsp_err, ce_n, cle, ale, we_n, re_n, io_oe, rb_n;
  logic [7:0] rsp_rdata, io_out, io_in;
  nch_col_t col_ptr;
  nch_col_t c; // Column under test
  logic [31:0] lfsr = 32'h631F; // Random state
  logic [7:0] buf_q [0:3]; // Bytes written
  int n_errors = 0;
  int checks = 0;
  int j;
  int k;
  always #10 sys_clk = ~sys_clk;
  nch_host dut_u (.sys_clk, .rst, .req_valid, .req_ready, .req_op, .req_col, .req_row,
    .req_wdata, .rsp_valid, .rsp_err, .rsp_rdata, .array_idle_flag, .prog_open, .prog_row,
    .multi_die, .multi_die_start, .col_ptr, .ce_n, .cle, .ale, .we_n, .re_n, .io_out,
    .io_oe, .io_in, .rb_n);
  nch_die_model model_u (.sys_clk, .ce_n, .cle, .ale, .we_n, .re_n, .io_out, .busy,
    .io_in, .rb_n);
  // Next state of the random source
  function logic [31:0] nxt_rand(input logic [31:0] s);
    nxt_rand = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt_rand
  // Report counts and end the run
  task stop_test;
    $display("errors=%0d checks=%0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  // Compare seen against expected
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // One request, held until taken, then wait for its answer
  task run(input nch_op_t o, input nch_col_t cc, input nch_row_t r, input logic [7:0] d,
    input logic e);
    int i;
    i = 0;
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req_op <= o;
    req_col <= cc;
    req_row <= r;
    req_wdata <= d;
    do begin
      @(posedge sys_clk);
      i++;
    end while (req_ready !== 1'b1 && i < 400);
    req_valid <= 1'b0;
    do begin
      @(posedge sys_clk);
      i++;
    end while (rsp_valid !== 1'b1 && i < 400);
    if (i >= 400) begin
      n_errors++;
      stop_test();
    end
    chk(rsp_err, e);
  endtask : run
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    busy <= 1'b1;
    repeat (4) @(posedge sys_clk);
    run(OP_COL_READ, 12'h000, 18'h00000, 8'h00, 1'b1);
    busy <= 1'b0;
    array_idle_flag <= 1'b0;
    repeat (4) @(posedge sys_clk);
    run(OP_PLANE_READ, 12'h000, prog_row, 8'h00, 1'b1);
    run(OP_COL_READ, 12'h010, 18'h00000, 8'h00, 1'b0);
    array_idle_flag <= 1'b1;
    run(OP_DATA_WR, 12'h000, 18'h00000, 8'h3C, 1'b1);
    run(OP_COL_INPUT, 12'h020, 18'h00000, 8'h00, 1'b1);
    prog_open <= 1'b1;
    for (k = 0; k < 4; k++) begin
      lfsr = nxt_rand(lfsr);
      c = (k == 0) ? 12'hFFF : lfsr[11:0];
      run(k[0] ? OP_RETARGET : OP_COL_INPUT, c, prog_row, 8'h00, 1'b0);
      chk(model_u.cmd, 8'h85);
      for (j = 0; j < 4; j++) begin
        lfsr = nxt_rand(lfsr);
        buf_q[j] = lfsr[7:0];
        run(OP_DATA_WR, 12'h000, 18'h00000, buf_q[j], 1'b0);
        chk(model_u.mem[nch_col_t'(c + j)], buf_q[j]);
      end
      chk(col_ptr, nch_col_t'(c + 4));
      if (k[0]) chk(model_u.row, prog_row);
      run(OP_DATA_RD, 12'h000, 18'h00000, 8'h00, 1'b1);
      run(k[1] ? OP_PLANE_READ : OP_COL_READ, c, prog_row, 8'h00, 1'b0);
      chk(model_u.cmd, 8'hE0);
      for (j = 0; j < 4; j++) begin
        run(OP_DATA_RD, 12'h000, 18'h00000, 8'h00, 1'b0);
        chk(rsp_rdata, buf_q[j]);
      end
    end
    run(OP_RETARGET, 12'h000, prog_row ^ 18'h20000, 8'h00, 1'b1);
    multi_die <= 1'b1;
    multi_die_start <= 1'b1;
    @(posedge sys_clk);
    multi_die_start <= 1'b0;
    run(OP_COL_READ, 12'h002, 18'h00000, 8'h00, 1'b1);
    run(OP_STATUS_ENH, 12'h000, prog_row, 8'h00, 1'b0);
    chk(model_u.cmd, 8'h78);
    run(OP_DATA_RD, 12'h000, 18'h00000, 8'h00, 1'b0);
    run(OP_COL_READ, 12'h002, 18'h00000, 8'h00, 1'b0);
    stop_test();
  end
endmodule : tb_top
